// >>> logic/cem_pkg.sv
// package: register map, field positions and state types of the error mask block
package cem_pkg;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS = 12'h110;
    localparam logic [11:0] OFS_MASK = 12'h114;
    localparam logic [11:0] OFS_IECTL = 12'h130;
    localparam logic [11:0] OFS_IRQMSK = 12'h134;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_RECEIVER = 0;
    localparam int BIT_BAD_PACKET = 6;
    localparam int BIT_BAD_LINK_PACKET = 7;
    localparam int BIT_ROLLOVER = 8;
    localparam int BIT_REPLAY_TIMEOUT = 12;
    localparam int BIT_ADVISORY = 13;
    localparam int BIT_INTERNAL = 14;
    localparam int BIT_HDR_OVERFLOW = 15;
    localparam int BIT_IE_ENABLE = 0;

    // implemented error classes; every other bit is reserved
    localparam logic [15:0] IMPL_BITS = 16'hf1c1;
    // classes locked by the internal error reporting enable
    localparam logic [15:0] INTERNAL_BITS = 16'hc000;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] MASK_RST = 16'he000;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic IE_ENABLE_RST = 1'b1;
    localparam logic [15:0] IRQMSK_RST = 16'hffff;

    // ---------------------------------------------------------------
    // state records
    // ---------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [15:0] mask;
        logic ien;
        logic [15:0] irq_mask;
        logic irq;
    } cem_core_t;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] report;
    } cem_trk_t;

endpackage : cem_pkg

// >>> logic/cem_evt_if.sv
// interface: error events, report blocking and status between core and tracker
`timescale 1ns/1ps
`default_nettype none
interface cem_evt_if;
    logic [15:0] event_in; // one-cycle error event pulses
    logic [15:0] block; // classes whose report is suppressed
    logic [15:0] clear; // one-cycle write-one-to-clear strobes
    logic [15:0] status; // sticky status bits
    logic [15:0] report; // one-cycle report pulses

    modport core (output event_in, output block, output clear, input status, input report);
    modport tracker (input event_in, input block, input clear, output status, output report);
endinterface : cem_evt_if
`default_nettype wire

// >>> logic/cem_tracker.sv
// tracker: sticky correctable error status and report pulse generation
`timescale 1ns/1ps
`default_nettype none
module cem_tracker (
    input wire logic clk, // block clock
    input wire logic rst_n, // power-on reset, active low
    cem_evt_if.tracker ev // events in, status and reports out
);

    cem_pkg::cem_trk_t st;
    cem_pkg::cem_trk_t next_st;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        next_st = st;
        next_st.status = (st.status & ~ev.clear) | (ev.event_in & cem_pkg::IMPL_BITS);
        next_st.report = ev.event_in & ~ev.block & cem_pkg::IMPL_BITS;
    end

    // state register; no link reset here since status is sticky
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{status: cem_pkg::STATUS_RST, report: 16'h0000};
        end else begin
            st <= next_st;
        end
    end

    assign ev.status = st.status;
    assign ev.report = st.report;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_status_always_set: assert property (
        (|(ev.event_in & cem_pkg::IMPL_BITS)) |=>
        ((st.status & $past(ev.event_in & cem_pkg::IMPL_BITS))
            == $past(ev.event_in & cem_pkg::IMPL_BITS)))
        else $error("event did not set its status bit");

    a_receiver_w1c: assert property (
        ev.clear[cem_pkg::BIT_RECEIVER] && !ev.event_in[cem_pkg::BIT_RECEIVER]
        |=> !st.status[cem_pkg::BIT_RECEIVER])
        else $error("receiver status not cleared by write of one");

endmodule : cem_tracker
`default_nettype wire

// >>> logic/cem_top.sv
// top: correctable error mask register bank with wishbone slave and interrupt
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Function
// - a set mask bit stops the matching correctable error from being reported.
// - mask changes never touch status, and status is recorded even when masked.
// - bit 8 masks replay number rollover, is writable and resets to zero.
// - bit 12 masks replay timer timeout, is writable and resets to zero.
// - bit 13 masks advisory non-fatal errors, is writable and resets to one.
// - bit 14 masks correctable internal errors and resets to one.
// - bit 15 masks header log overflow and resets to one.
// - with internal reporting disabled, bits 14 and 15 ignore writes and read zero.
// - receiver error status sets on a receiver error and clears by writing one.
module cem_top (
    input wire logic MCLK, // block clock, 10 MHz
    input wire logic NRST, // power-on reset, active low, asynchronous
    input wire logic LINK_RST, // non-fundamental reset pulse, same clock
    input wire logic [15:0] EVT, // error event pulses, same clock
    output logic [15:0] ERR_REPORT, // report pulses to the root complex
    output logic IRQ, // level interrupt
    input wire logic CYC_I, // wishbone cycle
    input wire logic STB_I, // wishbone strobe
    input wire logic WE_I, // wishbone write enable
    input wire logic [11:0] ADR_I, // wishbone byte address
    input wire logic [3:0] SEL_I, // wishbone byte selects
    input wire logic [31:0] DAT_I, // wishbone write data
    output logic [31:0] DAT_O, // wishbone read data
    output logic ACK_O // wishbone acknowledge
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // address match, used by decode, write and checks
    function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
        hit = (adr[11:2] == ofs[11:2]);
    endfunction : hit

    // byte lane mask over the low half word
    function automatic logic [15:0] lanes(input logic [3:0] sel);
        lanes = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction : lanes

    // ---------------------------------------------------------------
    // state and links
    // ---------------------------------------------------------------
    cem_pkg::cem_core_t st;
    cem_pkg::cem_core_t next_st;
    cem_evt_if ev ();

    logic req;
    logic commit;
    logic [15:0] wr_lanes;
    logic [15:0] lock;
    logic [15:0] mask_view;
    logic [15:0] mask_writable;
    logic [31:0] rd_value;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    // new request is answered one edge later; write lands on the ack edge
    assign req = CYC_I && STB_I && !st.ack;
    assign commit = CYC_I && STB_I && st.ack && WE_I;
    assign wr_lanes = lanes(SEL_I);

    // internal classes are locked to zero while reporting is disabled
    assign lock = st.ien ? 16'h0000 : cem_pkg::INTERNAL_BITS;
    assign mask_view = st.mask & ~lock;
    assign mask_writable = cem_pkg::IMPL_BITS & ~lock;

    // read multiplexer; unmapped addresses and reserved bits read zero, except the irq mask, which reads all 16 of its bits
    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit(ADR_I, cem_pkg::OFS_STATUS)) begin
            rd_value = {16'h0000, ev.status};
        end else if (hit(ADR_I, cem_pkg::OFS_MASK)) begin
            rd_value = {16'h0000, mask_view};
        end else if (hit(ADR_I, cem_pkg::OFS_IECTL)) begin
            rd_value = {31'h0, st.ien};
        end else if (hit(ADR_I, cem_pkg::OFS_IRQMSK)) begin
            rd_value = {16'h0000, st.irq_mask};
        end
    end

    // ---------------------------------------------------------------
    // tracker hookup
    // ---------------------------------------------------------------
    // disabled internal classes are not reported even though mask reads zero
    assign ev.event_in = EVT;
    assign ev.block = mask_view | lock;
    assign ev.clear = (commit && hit(ADR_I, cem_pkg::OFS_STATUS)) ?
        (DAT_I[15:0] & wr_lanes & cem_pkg::IMPL_BITS) : 16'h0000;

    cem_tracker u_tracker (
        .clk (MCLK),
        .rst_n (NRST),
        .ev (ev)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = req;
        if (req && !WE_I) begin
            next_st.dat = rd_value;
        end
        // only writable bits follow the bus; status is left alone
        if (commit && hit(ADR_I, cem_pkg::OFS_MASK)) begin
            next_st.mask = (st.mask & ~(wr_lanes & mask_writable))
                | (DAT_I[15:0] & wr_lanes & mask_writable);
        end
        if (commit && hit(ADR_I, cem_pkg::OFS_IECTL) && SEL_I[0]) begin
            next_st.ien = DAT_I[cem_pkg::BIT_IE_ENABLE];
        end
        if (commit && hit(ADR_I, cem_pkg::OFS_IRQMSK)) begin
            next_st.irq_mask = (st.irq_mask & ~wr_lanes) | (DAT_I[15:0] & wr_lanes);
        end
        // irq trails the status bits by one edge to stay a clean flop
        next_st.irq = |(ev.status & ~st.irq_mask);
        // link reset spares the sticky mask but restores the enable, irq mask and ack
        if (LINK_RST) begin
            next_st.ien = cem_pkg::IE_ENABLE_RST;
            next_st.irq_mask = cem_pkg::IRQMSK_RST;
            next_st.ack = 1'b0;
        end
    end

    // state register
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st <= '{
                ack: 1'b0,
                dat: 32'h0000_0000,
                mask: cem_pkg::MASK_RST,
                ien: cem_pkg::IE_ENABLE_RST,
                irq_mask: cem_pkg::IRQMSK_RST,
                irq: 1'b0
            };
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign ACK_O = st.ack;
    assign DAT_O = st.dat;
    assign IRQ = st.irq;
    assign ERR_REPORT = ev.report;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // first cycle after release of the power-on reset
    logic boot;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            boot <= 1'b1;
        end else begin
            boot <= 1'b0;
        end
    end

    sequence s_mask_wr;
        CYC_I && STB_I && WE_I && ACK_O && hit(ADR_I, cem_pkg::OFS_MASK);
    endsequence

    sequence s_mask_rd;
        CYC_I && STB_I && !WE_I && ACK_O && hit(ADR_I, cem_pkg::OFS_MASK);
    endsequence

    a_masked_quiet: assert property (
        (|ERR_REPORT) |-> ((ERR_REPORT & $past(ev.block)) == 16'h0000))
        else $error("masked class was reported");

    a_rollover_rst: assert property (
        boot |-> !st.mask[cem_pkg::BIT_ROLLOVER])
        else $error("rollover mask reset value wrong");

    a_rollover_write: assert property (
        s_mask_wr and SEL_I[1] |=>
        st.mask[cem_pkg::BIT_ROLLOVER] == $past(DAT_I[cem_pkg::BIT_ROLLOVER]))
        else $error("rollover mask not written");

    a_timeout_rst: assert property (
        boot |-> !st.mask[cem_pkg::BIT_REPLAY_TIMEOUT])
        else $error("replay timeout mask reset value wrong");

    a_timeout_write: assert property (
        s_mask_wr and SEL_I[1] |=>
        st.mask[cem_pkg::BIT_REPLAY_TIMEOUT] == $past(DAT_I[cem_pkg::BIT_REPLAY_TIMEOUT]))
        else $error("replay timeout mask not written");

    a_advisory_mask: assert property (
        s_mask_wr and SEL_I[1] |=>
        st.mask[cem_pkg::BIT_ADVISORY] == $past(DAT_I[cem_pkg::BIT_ADVISORY]))
        else $error("advisory mask not written");

    a_advisory_rst: assert property (
        boot |-> st.mask[cem_pkg::BIT_ADVISORY])
        else $error("advisory mask reset value wrong");

    a_internal_rst: assert property (
        boot |-> st.mask[cem_pkg::BIT_INTERNAL])
        else $error("internal mask reset value wrong");

    a_overflow_rst: assert property (
        boot |-> st.mask[cem_pkg::BIT_HDR_OVERFLOW])
        else $error("header overflow mask reset value wrong");

    a_locked_read: assert property (
        s_mask_rd and !st.ien |-> DAT_O[15:14] == 2'b00)
        else $error("locked mask bits read non-zero");

    a_locked_write: assert property (
        s_mask_wr and !st.ien |=> st.mask[15:14] == $past(st.mask[15:14]))
        else $error("locked mask bits took a write");

    a_sticky_hold: assert property (
        LINK_RST && !(WE_I && ACK_O) |=> st.mask == $past(st.mask))
        else $error("mask lost over link reset");

    a_reserved_zero: assert property (
        s_mask_rd |-> (DAT_O & ~{16'h0000, cem_pkg::IMPL_BITS}) == 32'h0000_0000)
        else $error("reserved mask bits read non-zero");

    // ---------------------------------------------------------------
    // report, lock and sticky state checks
    // ---------------------------------------------------------------
    // an event that passes the mask reaches the root complex exactly one cycle later
    a_report_pass: assert property (
        (|EVT) |=> ERR_REPORT == $past(EVT & cem_pkg::IMPL_BITS & ~ev.block))
        else $error("unmasked class not reported");

    // link layer classes checked one by one against their own mask bit
    a_receiver_quiet: assert property (
        EVT[cem_pkg::BIT_RECEIVER] && st.mask[cem_pkg::BIT_RECEIVER] |=>
        !ERR_REPORT[cem_pkg::BIT_RECEIVER])
        else $error("masked receiver error was reported");

    a_packet_quiet: assert property (
        EVT[cem_pkg::BIT_BAD_PACKET] && st.mask[cem_pkg::BIT_BAD_PACKET] |=>
        !ERR_REPORT[cem_pkg::BIT_BAD_PACKET])
        else $error("masked bad packet error was reported");

    a_link_packet_quiet: assert property (
        EVT[cem_pkg::BIT_BAD_LINK_PACKET] && st.mask[cem_pkg::BIT_BAD_LINK_PACKET] |=>
        !ERR_REPORT[cem_pkg::BIT_BAD_LINK_PACKET])
        else $error("masked bad link packet error was reported");

    // a mask write must not clear any status bit
    a_status_kept_mask: assert property (
        s_mask_wr |=> (ev.status & $past(ev.status)) == $past(ev.status))
        else $error("mask write disturbed status");

    // suppressed classes are still recorded in status
    a_masked_recorded: assert property (
        (|(EVT & cem_pkg::IMPL_BITS & ev.block)) |=>
        (ev.status & $past(EVT & cem_pkg::IMPL_BITS)) == $past(EVT & cem_pkg::IMPL_BITS))
        else $error("masked event not recorded in status");

    a_internal_write: assert property (
        s_mask_wr and SEL_I[1] and st.ien |=>
        st.mask[cem_pkg::BIT_INTERNAL] == $past(DAT_I[cem_pkg::BIT_INTERNAL]))
        else $error("internal mask not written");

    a_overflow_write: assert property (
        s_mask_wr and SEL_I[1] and st.ien |=>
        st.mask[cem_pkg::BIT_HDR_OVERFLOW] == $past(DAT_I[cem_pkg::BIT_HDR_OVERFLOW]))
        else $error("header overflow mask not written");

    // disabled internal classes stay blocked although their mask reads zero
    a_locked_block: assert property (
        !st.ien |-> (ev.block & cem_pkg::INTERNAL_BITS) == cem_pkg::INTERNAL_BITS)
        else $error("locked class not blocked");

    a_reserved_write: assert property (
        s_mask_wr |=> (st.mask & ~cem_pkg::IMPL_BITS) == 16'h0000)
        else $error("reserved mask bits took a write");

    a_unmapped_zero: assert property (
        CYC_I && STB_I && !WE_I && ACK_O && !hit(ADR_I, cem_pkg::OFS_STATUS)
        && !hit(ADR_I, cem_pkg::OFS_MASK) && !hit(ADR_I, cem_pkg::OFS_IECTL)
        && !hit(ADR_I, cem_pkg::OFS_IRQMSK) |-> DAT_O == 32'h0000_0000)
        else $error("unmapped address read non-zero");

    // link reset restores the enable but leaves status alone
    a_link_enable: assert property (
        LINK_RST |=> st.ien)
        else $error("enable not restored by link reset");

    a_link_status: assert property (
        LINK_RST |=> (ev.status & $past(ev.status)) == $past(ev.status))
        else $error("status lost over link reset");

endmodule : cem_top
`default_nettype wire

// >>> testbench/cem_root_model.sv
// partner model: root complex side collecting correctable error report pulses
`timescale 1ns/1ps
`default_nettype none
module cem_root_model (
    input wire logic clk, // block clock
    input wire logic rst_n, // power-on reset, active low
    input wire logic [15:0] report, // report pulses from the device
    input wire logic clr, // forget what was collected
    output logic [15:0] seen, // classes reported since the last clear
    output logic [7:0] pulses // cycles carrying any report
);
    // ---------------------------------------------------------------
    // collection
    // ---------------------------------------------------------------
    // counting cycles, not bits, exposes a report held longer than one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 16'h0000;
            pulses <= 8'h00;
        end else if (clr) begin
            seen <= 16'h0000;
            pulses <= 8'h00;
        end else begin
            seen <= seen | report;
            pulses <= pulses + {7'h00, |report};
        end
    end
endmodule : cem_root_model
`default_nettype wire

// >>> testbench/correctable_error_mask_tb_top.sv
// testbench: register, report and interrupt checks of the error mask block
`timescale 1ns/1ps
`default_nettype none
module correctable_error_mask_tb_top;
    logic mclk, nrst, link_rst, cyc, stb, we, clr, irq, ack;
    logic [15:0] evt, rep, seen;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, v, m, lfsr;
    logic [7:0] pulses;
    logic [15:0] e;
    int n_fail, comparisons, cycles;

    cem_top dut_u (.MCLK(mclk), .NRST(nrst), .LINK_RST(link_rst), .EVT(evt), .ERR_REPORT(rep),
        .IRQ(irq), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
        .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack));
    cem_root_model rc_u (.clk(mclk), .rst_n(nrst), .report(rep), .clr(clr), .seen(seen),
        .pulses(pulses));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] nxt(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h000000c5 : 32'h00000000);
    endfunction : nxt

    // reports expected once mask, reserved bits and the enable lock apply
    function automatic logic [15:0] exp_rep(logic [15:0] ev, logic [15:0] mk, logic ien);
        return ev & cem_pkg::IMPL_BITS & ~mk & (ien ? 16'hffff : ~cem_pkg::INTERNAL_BITS);
    endfunction : exp_rep

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        // no cycle count assumed; only the global cycle ceiling ends a hang
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    // one-cycle event burst after clearing the collected reports
    task automatic fire(input logic [15:0] ev);
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        evt <= ev;
        @(posedge mclk);
        evt <= 16'h0000;
        repeat (3) @(posedge mclk);
    endtask : fire

    // ---------------------------------------------------------------
    // clock and hang guard
    // ---------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {nrst, link_rst, cyc, stb, we, clr} = 6'h00;
        evt = 16'h0000;
        adr = 12'h000;
        sel = 4'h0;
        dat = 32'h0;
        lfsr = 32'hd3c1;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        wb(1'b0, cem_pkg::OFS_MASK, 32'h0, v);
        chk("mask reset", v, 32'h0000e000);
        wb(1'b0, 12'h200, 32'h0, v);
        chk("unmapped", v, 32'h0);
        // random masks and events, first two rounds are the extremes
        for (int i = 0; i < 64; i++) begin
            lfsr = nxt(lfsr);
            m = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : lfsr;
            lfsr = nxt(lfsr);
            e = (i < 2) ? 16'hffff : lfsr[31:16];
            wr(cem_pkg::OFS_MASK, m);
            wb(1'b0, cem_pkg::OFS_MASK, 32'h0, v);
            chk("mask", v, {16'h0, m[15:0] & cem_pkg::IMPL_BITS});
            fire(e);
            chk("report", {16'h0, seen}, {16'h0, exp_rep(e, m[15:0], 1'b1)});
            chk("pulses", {24'h0, pulses}, (exp_rep(e, m[15:0], 1'b1) != 0) ? 1 : 0);
            wb(1'b0, cem_pkg::OFS_STATUS, 32'h0, v);
            chk("status", v, {16'h0, e & cem_pkg::IMPL_BITS});
            wr(cem_pkg::OFS_STATUS, 32'h0000ffff);
            wb(1'b0, cem_pkg::OFS_STATUS, 32'h0, v);
            chk("status clear", v, 32'h0);
        end
        // internal reporting off: bits 14 and 15 locked at zero
        wr(cem_pkg::OFS_MASK, 32'h0000c000);
        wr(cem_pkg::OFS_IECTL, 32'h0);
        wb(1'b0, cem_pkg::OFS_MASK, 32'h0, v);
        chk("mask locked", v, 32'h0);
        wr(cem_pkg::OFS_MASK, 32'h00001041);
        fire(16'hc001);
        chk("locked report", {16'h0, seen}, {16'h0, exp_rep(16'hc001, 16'h1041, 1'b0)});
        wb(1'b0, cem_pkg::OFS_STATUS, 32'h0, v);
        chk("locked status", v, 32'h0000c001);
        // link reset restores the enable and keeps the sticky mask
        @(posedge mclk);
        link_rst <= 1'b1;
        @(posedge mclk);
        link_rst <= 1'b0;
        wb(1'b0, cem_pkg::OFS_MASK, 32'h0, v);
        chk("mask sticky", v, 32'h0000d041);
        // interrupt raised, masked and cleared
        wr(cem_pkg::OFS_IRQMSK, 32'h0000fffe);
        repeat (2) @(posedge mclk);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(cem_pkg::OFS_IRQMSK, 32'h0000ffff);
        repeat (2) @(posedge mclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(cem_pkg::OFS_IRQMSK, 32'h0000fffe);
        wr(cem_pkg::OFS_STATUS, 32'h0000ffff);
        repeat (2) @(posedge mclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        final_report();
    end
endmodule : correctable_error_mask_tb_top
`default_nettype wire
